// *** rtl/phy_link_diagnostics.sv ***
`timescale 1ns/100ps
// Notes on behaviour
// - Present quality level in quality bits 3:1.
// - Worst level since last read in 7:5.
// - Eight levels, 0 worst, 7 best.
// - Quality follows the noise measure while linked.
// - Discharge sensed on each line pin separately.
// - Discharge event sets status bit 11.
// - Bit 3 routes discharge flag to interrupt pin.
// - Six-bit event count in bits 14:9.
// - Event count cleared only by power cycle.
// - Run sends pulse, times and weighs reflections.
// - Partner silent; link held down during run.
// - Status reads 0b10 after a good run.
// - Result bit 8 flags half-wire open.
// - Result bit 7 flags cable fault.
// - Result bit 6: zero open, one short.
// - Fault distance in metres in bits 5:0.
module phy_link_diagnostics
   import link_diag_pkg::*;
#(
   parameter int RUN_CYCLES    = TDR_RUN_CYC,
   parameter int AMP_THRESHOLD = 32
) (
   // Clock and resets.
   input  wire logic                    ref_clk_i,
   input  wire logic                    reset_i,
   input  wire logic                    power_on_reset_i,
   // Management register port.
   input  wire link_diag_pkg::reg_req_t reg_req_i,
   output logic [15:0]                  reg_rdata_o,
   // Receiver quality measurement.
   input  wire logic                    link_active_i,
   input  wire logic [2:0]              snr_level_i,
   // Discharge sensor pins.
   input  wire logic                    esd_pin_p_i,
   input  wire logic                    esd_pin_n_i,
   // Reflectometry front end.
   input  wire link_diag_pkg::echo_t    echo_i,
   input  wire logic                    partner_energy_i,
   output logic                         tdr_pulse_o,
   output logic                         link_hold_down_o,
   // Interrupt pin.
   output logic                         int_n_o
);

   import link_diag_pkg::*;

   // Refuse a run too short to hold the pulse, or a threshold off the amplitude scale.
   // The run timer is 32 bits wide, which covers any run length an int can name.
   if (RUN_CYCLES <= TDR_PULSE_CYC || AMP_THRESHOLD < 1 || AMP_THRESHOLD > 255) begin : g_chk
      $error("phy_link_diagnostics: bad parameter");
   end

   // Constant forms of the parameters, sized to the registers that they meet.
   localparam logic [7:0]  AMP_THR = AMP_THRESHOLD[7:0];    // Fault amplitude threshold.
   localparam logic [31:0] RUN_LAST = 32'(RUN_CYCLES - 1);  // Last cycle of a run.
   localparam logic [31:0] PULSE_LAST = 32'(TDR_PULSE_CYC - 1);  // Last pulse cycle.

   // Run sequencer states.
   typedef enum logic [1:0] {
      S_IDLE,
      S_PULSE,
      S_LISTEN
   } tdr_state_t;

   // Decoded accesses.
   // Writes and reads arrive as one-cycle strobes from the management port.
   logic isr_rd;       // Interrupt status read.
   logic isr_wr;       // Interrupt status write.
   logic ctrl_wr;      // Reflectometry control write.
   logic qual_rd;      // Quality register read.

   // Decoding is combinational, so an access acts on the very edge that samples it.
   always_comb begin
      isr_rd  = reg_req_i.rd && (reg_req_i.addr == ISR_OFFS);
      isr_wr  = reg_req_i.wr && (reg_req_i.addr == ISR_OFFS);
      ctrl_wr = reg_req_i.wr && (reg_req_i.addr == TDR_CTRL_OFFS);
      qual_rd = reg_req_i.rd && (reg_req_i.addr == QUAL_OFFS);
   end

   // Link quality: present level and worst level since the last read.
   logic [2:0] qual_now_ff;    // Present level.
   logic [2:0] qual_worst_ff;  // Lowest level since last read.
   logic [2:0] nxt_qual_now;   // Level to present next cycle.

   // With no link the level reads worst, which also falls in the poor band.
   always_comb begin
      nxt_qual_now = link_active_i ? snr_level_i : QUAL_WORST;
   end

   // While linked, the present level follows the measurement every cycle.
   // No filtering is applied here; the measurement already averages its samples.
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         qual_now_ff <= QUAL_WORST;
      end else begin
         qual_now_ff <= nxt_qual_now;
      end
   end

   // Worst tracking starts at the reset level of the present field, so a read
   // straight after reset never shows a worst level above the present one.
   // A read reloads from the incoming level, and a dip in the read cycle is kept.
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         qual_worst_ff <= QUAL_WORST;
      end else if (qual_rd) begin
         qual_worst_ff <= nxt_qual_now;
      end else if (nxt_qual_now < qual_worst_ff) begin
         qual_worst_ff <= nxt_qual_now;
      end
   end

   // Discharge sensing: synchroniser, per-pin edges, flag and event count.
   logic [1:0] esd_meta_ff;   // First synchroniser stage, pins p and n.
   logic [1:0] esd_sync_ff;   // Second synchroniser stage.
   logic [1:0] esd_prev_ff;   // Previous synchronised level for edges.
   logic [1:0] esd_edge;      // Rising edge per pin.
   logic       esd_event;     // Any pin saw a new event.
   logic       esd_flag_ff;   // Sticky event flag.
   logic       esd_int_en_ff; // Route flag to the pin.
   logic [5:0] esd_cnt_ff;    // Event count kept since power-up.

   // The sensor pulses are asynchronous; two flops before anything looks.
   // Only the second stage feeds logic, since the first may still be settling.
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         esd_meta_ff <= 2'h0;
         esd_sync_ff <= 2'h0;
         esd_prev_ff <= 2'h0;
      end else begin
         esd_meta_ff <= {esd_pin_n_i, esd_pin_p_i};
         esd_sync_ff <= esd_meta_ff;
         esd_prev_ff <= esd_sync_ff;
      end
   end

   // Each pin has its own edge detector so events stay apart.
   // A pin held high counts once, since only its rising step is an event.
   always_comb begin
      esd_edge  = esd_sync_ff & ~esd_prev_ff;
      esd_event = |esd_edge;
   end

   // Flag is cleared by reading; an event in the read cycle still sets it.
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         esd_flag_ff <= 1'b0;
      end else if (esd_event) begin
         esd_flag_ff <= 1'b1;
      end else if (isr_rd) begin
         esd_flag_ff <= 1'b0;
      end
   end

   // Interrupt routing enable.
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         esd_int_en_ff <= 1'b0;
      end else if (isr_wr) begin
         esd_int_en_ff <= reg_req_i.wdata[ISR_ESD_EN_BIT];
      end
   end

   // Counter sits only on the power-on reset so ordinary resets leave it.
   // Two pins hit in one cycle count as two; the count stops at full scale
   // rather than wrapping back to a misleading small number.
   // Software has no way to clear it, which is intended.
   always_ff @(posedge ref_clk_i or posedge power_on_reset_i) begin
      if (power_on_reset_i) begin
         esd_cnt_ff <= 6'h00;
      end else if (esd_edge == 2'h3 && esd_cnt_ff < ESD_CNT_MAX - 6'h1) begin
         esd_cnt_ff <= esd_cnt_ff + 6'h2;
      end else if (esd_event && esd_cnt_ff != ESD_CNT_MAX) begin
         esd_cnt_ff <= esd_cnt_ff + 6'h1;
      end
   end

   // Active-low pin, low while the flag is up and routed.
   // The flag stays set while routing is off, so enabling later pulls the pin at once.
   always_comb begin
      int_n_o = ~(esd_int_en_ff & esd_flag_ff);
   end

   // Reflectometry: run sequencer, status and reflection results.
   tdr_state_t  state_ff;       // Sequencer state.
   logic [31:0] tmr_ff;         // Cycles since the pulse began.
   logic [1:0]  tdr_stat_ff;    // Run status.
   logic        res_half_ff;    // Half-wire open seen.
   logic        res_fault_ff;   // Cable fault seen.
   logic        res_short_ff;   // Fault is a short.
   logic [5:0]  res_dist_ff;    // Fault distance in metres.
   logic [7:0]  best_amp_ff;    // Strongest reflection so far.
   logic        disturbed_ff;   // Partner spoke during the run.
   logic [31:0] echo_m;         // Distance of this echo in metres.
   logic        strong_echo;    // Echo above threshold and strongest yet.
   logic        start_run;      // Software start request.

   always_comb begin
      start_run   = ctrl_wr && reg_req_i.wdata[TDR_START_BIT] && (state_ff == S_IDLE);
      echo_m      = tmr_ff / 32'(ECHO_CYC_PER_M);
      strong_echo = echo_i.valid && (echo_i.amp >= AMP_THR) && (echo_i.amp > best_amp_ff);
   end

   // Pulse, then listen for the rest of the run, then report.
   // Starts during a run are ignored; the run cannot be restarted midway.
   // The timer is zero in the first pulse cycle, so it counts echo flight
   // directly and the distance needs no offset.
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_ff <= S_IDLE;
         tmr_ff   <= 32'h0;
      end else begin
         case (state_ff)
            S_IDLE: begin
               tmr_ff <= 32'h0;
               if (start_run) begin
                  state_ff <= S_PULSE;
               end
            end
            S_PULSE: begin
               tmr_ff <= tmr_ff + 32'h1;
               if (tmr_ff == PULSE_LAST) begin
                  state_ff <= S_LISTEN;
               end
            end
            S_LISTEN: begin
               tmr_ff <= tmr_ff + 32'h1;
               if (tmr_ff == RUN_LAST) begin
                  state_ff <= S_IDLE;
               end
            end
            default: begin
               state_ff <= S_IDLE;
            end
         endcase
      end
   end

   // Status: busy from start, done or failed when listening ends.
   // Reading never clears it, so software may poll as often as it likes.
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         tdr_stat_ff <= TDR_ST_IDLE;
      end else if (start_run) begin
         tdr_stat_ff <= TDR_ST_BUSY;
      end else if (state_ff == S_LISTEN && tmr_ff == RUN_LAST) begin
         tdr_stat_ff <= disturbed_ff ? TDR_ST_FAIL : TDR_ST_DONE;
      end
   end

   // A talking partner spoils the echoes, so the run is marked failed.
   // Energy in the pulse phase counts too, since it lands on the same wire.
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         disturbed_ff <= 1'b0;
      end else if (start_run) begin
         disturbed_ff <= 1'b0;
      end else if (state_ff != S_IDLE && partner_energy_i) begin
         disturbed_ff <= 1'b1;
      end
   end

   // Every reflection heard while listening is timed and weighed; the strongest one above the
   // threshold decides type and place. Results clear at start.
   // A weaker later echo never overwrites a stronger one; this trades the
   // report of a near small joint for that of the real break behind it.
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         res_half_ff  <= 1'b0;
         res_fault_ff <= 1'b0;
         res_short_ff <= 1'b0;
         res_dist_ff  <= 6'h00;
         best_amp_ff  <= 8'h00;
      end else if (start_run) begin
         res_half_ff  <= 1'b0;
         res_fault_ff <= 1'b0;
         res_short_ff <= 1'b0;
         res_dist_ff  <= 6'h00;
         best_amp_ff  <= 8'h00;
      end else if (state_ff == S_LISTEN && echo_i.valid) begin
         if (echo_i.half_open) begin
            res_half_ff <= 1'b1;
         end
         if (strong_echo) begin
            best_amp_ff  <= echo_i.amp;
            res_fault_ff <= 1'b1;
            res_short_ff <= echo_i.is_short;
            res_dist_ff  <= (echo_m > 32'(DIST_MAX)) ? DIST_MAX : echo_m[5:0];
         end
      end
   end

   // Pulse drive and link hold-down come from the state flops.
   // Both change on the edge that starts the run, so nothing separates them.
   always_comb begin
      tdr_pulse_o      = (state_ff == S_PULSE);
      link_hold_down_o = (state_ff != S_IDLE);
   end

   // Read data. Results read back whatever the status; software is to
   // trust them only after status shows done. Unmapped reads return zero.
   logic [15:0] nxt_rdata;   // Assembled read word.
   logic [15:0] rdata_ff;    // Registered read word.

   always_comb begin
      nxt_rdata = REG_RESET;
      if (reg_req_i.addr == ISR_OFFS) begin
         nxt_rdata[ISR_ESD_FLAG_BIT] = esd_flag_ff;
         nxt_rdata[ISR_ESD_EN_BIT]   = esd_int_en_ff;
      end else if (reg_req_i.addr == TDR_CTRL_OFFS) begin
         nxt_rdata[TDR_START_BIT]                 = (state_ff != S_IDLE);
         nxt_rdata[TDR_STAT_LSB +: 2]             = tdr_stat_ff;
      end else if (reg_req_i.addr == TDR_RES_OFFS) begin
         nxt_rdata[RES_HALF_BIT]      = res_half_ff;
         nxt_rdata[RES_FAULT_BIT]     = res_fault_ff;
         nxt_rdata[RES_SHORT_BIT]     = res_short_ff;
         nxt_rdata[RES_DIST_LSB +: 6] = res_dist_ff;
      end else if (reg_req_i.addr == ESD_CNT_OFFS) begin
         nxt_rdata[ESD_CNT_LSB +: 6] = esd_cnt_ff;
      end else if (reg_req_i.addr == QUAL_OFFS) begin
         nxt_rdata[QUAL_NOW_LSB +: 3]   = qual_now_ff;
         nxt_rdata[QUAL_WORST_LSB +: 3] = qual_worst_ff;
      end
   end

   // Data is captured on the read strobe and held until the next read.
   // Holding the word lets a slow reader sample it at leisure.
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         rdata_ff <= REG_RESET;
      end else if (reg_req_i.rd) begin
         rdata_ff <= nxt_rdata;
      end
   end

   // The port shows the held word straight from its flop.
   assign reg_rdata_o = rdata_ff;

endmodule  // phy_link_diagnostics

// *** rtl/link_diag_pkg.sv ***
package link_diag_pkg;

   // Register offsets of the management map.
   localparam logic [15:0] ISR_OFFS      = 16'h0012;
   localparam logic [15:0] TDR_CTRL_OFFS = 16'h001e;
   localparam logic [15:0] TDR_RES_OFFS  = 16'h0310;
   localparam logic [15:0] ESD_CNT_OFFS  = 16'h0442;
   localparam logic [15:0] QUAL_OFFS     = 16'h0871;

   // Field positions.
   localparam int ISR_ESD_EN_BIT   = 3;
   localparam int ISR_ESD_FLAG_BIT = 11;
   localparam int TDR_START_BIT    = 15;
   localparam int TDR_STAT_LSB     = 0;
   localparam int RES_HALF_BIT     = 8;
   localparam int RES_FAULT_BIT    = 7;
   localparam int RES_SHORT_BIT    = 6;
   localparam int RES_DIST_LSB     = 0;
   localparam int ESD_CNT_LSB      = 9;
   localparam int QUAL_NOW_LSB     = 1;
   localparam int QUAL_WORST_LSB   = 5;

   // Quality levels.
   localparam logic [2:0] QUAL_WORST = 3'h0;
   localparam logic [2:0] QUAL_BEST  = 3'h7;

   // Run status codes in the low two bits of the control register.
   localparam logic [1:0] TDR_ST_IDLE = 2'h0;
   localparam logic [1:0] TDR_ST_BUSY = 2'h1;
   localparam logic [1:0] TDR_ST_DONE = 2'h2;
   localparam logic [1:0] TDR_ST_FAIL = 2'h3;

   // Reset value and field maxima.
   localparam logic [15:0] REG_RESET   = 16'h0000;
   localparam logic [5:0]  ESD_CNT_MAX = 6'h3f;
   localparam logic [5:0]  DIST_MAX    = 6'h3f;

   // Timing: clock, test pulse width, whole run and echo flight per metre.
   localparam int CLK_PERIOD_NS  = 10;
   localparam int TDR_PULSE_NS   = 80;
   localparam int TDR_RUN_US     = 1000;
   localparam int ECHO_NS_PER_M  = 10;
   localparam int SW_WAIT_MS     = 100;
   localparam int TDR_PULSE_CYC  = (TDR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TDR_RUN_CYC    = (TDR_RUN_US * 1000) / CLK_PERIOD_NS;
   localparam int ECHO_CYC_PER_M = (ECHO_NS_PER_M + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Register access request from the management port.
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [15:0] wdata;
   } reg_req_t;

   // One reflection reported by the analog echo detector.
   typedef struct packed {
      logic       valid;
      logic       is_short;
      logic       half_open;
      logic [7:0] amp;
   } echo_t;

endpackage

// *** verif/link_diag_props.sv ***
`timescale 1ns/100ps
// Port-level checks of the diagnostics block.
module link_diag_props
   import link_diag_pkg::*;
#(
   parameter int RUN_CYCLES    = TDR_RUN_CYC,
   parameter int AMP_THRESHOLD = 32
) (
   // Clock and resets.
   input wire logic                    ref_clk_i,
   input wire logic                    reset_i,
   input wire logic                    power_on_reset_i,
   // Register port.
   input wire link_diag_pkg::reg_req_t reg_req_i,
   input wire logic [15:0]             reg_rdata_o,
   // Line side and pins.
   input wire logic                    link_active_i,
   input wire logic [2:0]              snr_level_i,
   input wire logic                    esd_pin_p_i,
   input wire logic                    esd_pin_n_i,
   input wire link_diag_pkg::echo_t    echo_i,
   input wire logic                    partner_energy_i,
   input wire logic                    tdr_pulse_o,
   input wire logic                    link_hold_down_o,
   input wire logic                    int_n_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);

   logic        rd_qual; // A read of the quality register.
   logic [31:0] hold_cnt_ff; // Cycles the link has been held down.

   assign rd_qual = reg_req_i.rd && (reg_req_i.addr == QUAL_OFFS);

   // Counts the run length; a counter keeps the check cheap for long runs.
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         hold_cnt_ff <= 32'h0;
      end else begin
         hold_cnt_ff <= link_hold_down_o ? hold_cnt_ff + 32'h1 : 32'h0;
      end
   end

   property p_pulse_len;
      $rose(tdr_pulse_o) |-> tdr_pulse_o [*8] ##1 !tdr_pulse_o;
   endproperty
   a_pulse_len: assert property (p_pulse_len) else $error("test pulse length wrong");
   property p_pulse_first;
      $rose(link_hold_down_o) |-> $rose(tdr_pulse_o);
   endproperty
   a_pulse_first: assert property (p_pulse_first) else $error("run began without pulse");
   property p_pulse_in_run;
      tdr_pulse_o |-> link_hold_down_o;
   endproperty
   a_pulse_in_run: assert property (p_pulse_in_run) else $error("pulse with link up");
   property p_start;
      reg_req_i.wr && reg_req_i.addr == TDR_CTRL_OFFS && reg_req_i.wdata[15]
         && !link_hold_down_o |=> tdr_pulse_o && link_hold_down_o;
   endproperty
   a_start: assert property (p_start) else $error("start write ignored");
   property p_hold_len;
      $fell(link_hold_down_o) |-> hold_cnt_ff >= RUN_CYCLES - 1 && hold_cnt_ff <= RUN_CYCLES;
   endproperty
   a_hold_len: assert property (p_hold_len) else $error("run length wrong");
   property p_int_flag;
      !int_n_o && reg_req_i.rd && reg_req_i.addr == ISR_OFFS |=> reg_rdata_o[11] && reg_rdata_o[3];
   endproperty
   a_int_flag: assert property (p_int_flag) else $error("interrupt without flag");
   property p_qual_now;
      rd_qual && link_active_i && $past(link_active_i) && $stable(snr_level_i)
         && snr_level_i == $past(snr_level_i, 2) |=> reg_rdata_o[3:1] == $past(snr_level_i);
   endproperty
   a_qual_now: assert property (p_qual_now) else $error("quality level wrong");
   property p_worst;
      rd_qual |=> reg_rdata_o[7:5] <= reg_rdata_o[3:1];
   endproperty
   a_worst: assert property (p_worst) else $error("worst above present");
   property p_no_link;
      rd_qual && !link_active_i && !$past(link_active_i) |=> reg_rdata_o[3:1] == QUAL_WORST;
   endproperty
   a_no_link: assert property (p_no_link) else $error("quality without link");
endmodule // link_diag_props

bind phy_link_diagnostics link_diag_props #(.RUN_CYCLES(RUN_CYCLES), .AMP_THRESHOLD(AMP_THRESHOLD))
   u_props (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .power_on_reset_i(power_on_reset_i),
   .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o), .link_active_i(link_active_i),
   .snr_level_i(snr_level_i), .esd_pin_p_i(esd_pin_p_i), .esd_pin_n_i(esd_pin_n_i),
   .echo_i(echo_i), .partner_energy_i(partner_energy_i), .tdr_pulse_o(tdr_pulse_o),
   .link_hold_down_o(link_hold_down_o), .int_n_o(int_n_o));

// *** verif/cable_partner_model.sv ***
`timescale 1ns/100ps
// Cable and far-end partner as seen by the reflectometry front end.
module cable_partner_model
   import link_diag_pkg::*;
(
   // Clock and run indication.
   input  wire logic            ref_clk_i,
   input  wire logic            link_hold_down_i,
   // Bench commands: echo delay, fault kind, noisy partner.
   input  wire logic [15:0]     echo_dly_i,
   input  wire logic            echo_short_i,
   input  wire logic            echo_half_i,
   input  wire logic            noisy_i,
   // Line side.
   output link_diag_pkg::echo_t echo_o,
   output logic                 partner_energy_o
);
   logic [15:0] cnt; // Cycles since the run began.

   // The partner stays quiet unless told to misbehave.
   assign partner_energy_o = noisy_i & link_hold_down_i;

   initial begin
      cnt = 16'h0;
      echo_o = '0;
   end

   // One reflection per run; idle fields toggle so stale data never looks valid.
   always @(posedge ref_clk_i) begin
      #1;
      if (link_hold_down_i && cnt == echo_dly_i) begin
         echo_o <= '{1'b1, echo_short_i, echo_half_i, 8'h40};
      end else begin
         echo_o <= '{1'b0, ~echo_o.is_short, ~echo_o.half_open, ~echo_o.amp};
      end
      cnt <= link_hold_down_i ? cnt + 16'h1 : 16'h0;
   end
endmodule // cable_partner_model

// *** verif/phy_link_diagnostics_tb.sv ***
`timescale 1ns/100ps
// Self-checking bench for the link diagnostics block.
module phy_link_diagnostics_tb;
   import link_diag_pkg::*;
   logic        ref_clk_i, reset_i, por, link, esd_p, esd_n, pulse, hold, energy, int_n;
   logic        e_short, e_half, noisy;
   logic [2:0]  snr;
   logic [15:0] rdata, e_dly, got;
   reg_req_t    req;
   echo_t       echo;
   int          errors, checked;

   phy_link_diagnostics #(.RUN_CYCLES(40)) dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
      .power_on_reset_i(por), .reg_req_i(req), .reg_rdata_o(rdata), .link_active_i(link),
      .snr_level_i(snr), .esd_pin_p_i(esd_p), .esd_pin_n_i(esd_n), .echo_i(echo),
      .partner_energy_i(energy), .tdr_pulse_o(pulse), .link_hold_down_o(hold), .int_n_o(int_n));
   cable_partner_model partner (.ref_clk_i(ref_clk_i), .link_hold_down_i(hold),
      .echo_dly_i(e_dly), .echo_short_i(e_short), .echo_half_i(e_half), .noisy_i(noisy),
      .echo_o(echo), .partner_energy_o(energy));

   initial begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end

   task automatic summarize();
      $display("errors=%0d checked=%0d", errors, checked);
      if (errors == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      checked++;
      if (g !== e) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // Inputs change one step after the edge so sampling never races.
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask

   task automatic bus(input logic w, input logic [15:0] a, input logic [15:0] d);
      @(posedge ref_clk_i) #1 req = '{w, ~w, a, d};
      cyc(1);
      req = '0;
      got = rdata;
   endtask

   task automatic rd_chk(input logic [15:0] a, input logic [15:0] e);
      bus(1'b0, a, 16'h0);
      chk(got, e);
   endtask

   task automatic esd_pulse(input logic p, input logic n);
      @(posedge ref_clk_i) #1 {esd_p, esd_n} = {p, n};
      cyc(3);
      {esd_p, esd_n} = 2'b00;
      cyc(4);
   endtask

   // Reset values, a read-only write and an unmapped read.
   task automatic t_regs();
      rd_chk(ISR_OFFS, 16'h0000);
      rd_chk(TDR_CTRL_OFFS, {14'h0, TDR_ST_IDLE});
      rd_chk(ESD_CNT_OFFS, 16'h0000);
      bus(1'b1, TDR_RES_OFFS, 16'hffff);
      rd_chk(TDR_RES_OFFS, 16'h0000);
      rd_chk(16'h0100, 16'h0000);
   endtask

   // Every level, then a dip that the worst field must remember.
   task automatic t_quality();
      link = 1'b1;
      for (int i = 0; i < 8; i++) begin
         snr = i[2:0];
         cyc(4);
         bus(1'b0, QUAL_OFFS, 16'h0);
         rd_chk(QUAL_OFFS, {8'h0, i[2:0], 1'b0, i[2:0], 1'b0});
      end
      snr = 3'h2;
      cyc(4);
      snr = 3'h6;
      cyc(4);
      rd_chk(QUAL_OFFS, 16'h004c);
      link = 1'b0;
      cyc(4);
      rd_chk(QUAL_OFFS, 16'h0000);
   endtask

   // Events on each pin, the interrupt route and survival of the count.
   task automatic t_esd();
      bus(1'b1, ISR_OFFS, 16'h0008);
      esd_pulse(1'b1, 1'b0);
      chk({15'h0, int_n}, 16'h0000);
      rd_chk(ISR_OFFS, 16'h0808);
      chk({15'h0, int_n}, 16'h0001);
      esd_pulse(1'b1, 1'b1);
      rd_chk(ESD_CNT_OFFS, 16'h0600);
      bus(1'b1, ISR_OFFS, 16'h0000);
      esd_pulse(1'b0, 1'b1);
      chk({15'h0, int_n}, 16'h0001);
      rd_chk(ISR_OFFS, 16'h0800);
      reset_i = 1'b1;
      cyc(2);
      reset_i = 1'b0;
      rd_chk(ESD_CNT_OFFS, 16'h0800);
   endtask

   // One run; the echo lands at timer value dly, counted from the first pulse cycle.
   task automatic t_tdr(input logic [15:0] dly, input logic sh, input logic hf, input logic nz);
      int n;
      {e_dly, e_short, e_half, noisy} = {dly, sh, hf, nz};
      bus(1'b1, TDR_CTRL_OFFS, 16'h8000);
      rd_chk(TDR_CTRL_OFFS, {1'b1, 13'h0, TDR_ST_BUSY});
      for (n = 0; n < 200 && hold !== 1'b0; n++) cyc(1);
      chk({15'h0, hold}, 16'h0000);
      cyc(2);
      rd_chk(TDR_CTRL_OFFS, {14'h0, nz ? TDR_ST_FAIL : TDR_ST_DONE});
      if (!nz) rd_chk(TDR_RES_OFFS, (dly == 16'hffff) ? 16'h0 :
         {7'h0, hf, 1'b1, sh, dly[5:0]});
      noisy = 1'b0;
   endtask

   initial begin
      req = '0;
      {link, esd_p, esd_n, e_short, e_half, noisy} = 6'h0;
      snr = 3'h0;
      e_dly = 16'hffff;
      errors = 0;
      checked = 0;
      {reset_i, por} = 2'b11;
      repeat (5) @(posedge ref_clk_i);
      #1 {reset_i, por} = 2'b00;
      t_regs();
      t_quality();
      t_esd();
      t_tdr(16'd20, 1'b1, 1'b0, 1'b0);
      t_tdr(16'd30, 1'b0, 1'b1, 1'b0);
      t_tdr(16'hffff, 1'b0, 1'b0, 1'b0);
      t_tdr(16'd10, 1'b0, 1'b0, 1'b1);
      summarize();
   end

   // Cuts a hang short well past the expected few hundred cycles.
   initial begin
      #200us;
      errors++;
      summarize();
   end
endmodule // phy_link_diagnostics_tb
